// ===== sim/status_bank_monitor.sv
`timescale 1ns/100ps
module status_bank_monitor #(
  parameter logic [7:0] VERSION = 8'h00,
  parameter int CONV_CYCLES = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [status_bank_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic vco_range_finished,
  input wire logic [4:0] q_atten_db,
  input wire logic [4:0] i_atten_db,
  input wire logic conv_busy,
  input wire logic [3:0] completion_event
);
  // ************************************************************
  // helper logic
  // ************************************************************
  logic [15:0] busy_cnt;
  wire logic [7:0] idx = paddr[9:2];
  wire logic trig = ce && cmd_valid && (cmd_code == status_bank_pkg::CMD_TRIG_CONV);
  wire logic mapped = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0) &&
    (idx == status_bank_pkg::IDX_GAIN_VIEW || idx == status_bank_pkg::IDX_CONV_VIEW ||
     idx == status_bank_pkg::IDX_CMD_STATUS || idx == status_bank_pkg::IDX_PAGE_SETTING ||
     idx == status_bank_pkg::IDX_CHIP_VERSION);

  // restart on reissue, so the count runs from the latest command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_cnt <= 16'h0000;
    end else if (trig) begin
      busy_cnt <= 16'h0000;
    end else if (ce && conv_busy) begin
      busy_cnt <= busy_cnt + 16'h0001;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_BUSY_START: assert property (trig |=> conv_busy)
    else $error("conversion did not start");
  AST_BUSY_HOLD: assert property (conv_busy |-> busy_cnt < CONV_CYCLES)
    else $error("conversion runs too long");
  AST_BUSY_END: assert property (conv_busy && ce && !trig && busy_cnt == CONV_CYCLES - 1 |=> !conv_busy)
    else $error("conversion did not end on time");
  AST_CONV_EVENT: assert property ($fell(conv_busy) |=> completion_event[0])
    else $error("no conversion event");
  AST_VCO_EVENT: assert property (ce && vco_range_finished |=> completion_event[3])
    else $error("no vco event");
  AST_EVENT_PULSE: assert property ((completion_event & $past(completion_event)) == 4'h0)
    else $error("event longer than one cycle");
  AST_ATTEN_OFF: assert property (ce && cmd_valid && cmd_code == status_bank_pkg::CMD_GAIN_OFF |-> ##[1:2] (q_atten_db == 5'h00 && i_atten_db == 5'h00))
    else $error("attenuation not removed");
  AST_ATTEN_STEP: assert property (q_atten_db <= 5'h0C && q_atten_db % 3 == 0 && i_atten_db <= 5'h0C && i_atten_db % 3 == 0)
    else $error("attenuation off the step grid");
  AST_SLVERR: assert property (psel && penable |-> pslverr == !mapped)
    else $error("error response wrong");
  AST_VERSION: assert property (psel && penable && !pwrite && paddr == 12'h0CC |-> prdata == {24'h000000, VERSION})
    else $error("version read wrong");
endmodule

bind paged_status_readout status_bank_monitor #(.VERSION(VERSION), .CONV_CYCLES(CONV_CYCLES)) mon_inst (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
  .vco_range_finished(vco_range_finished), .q_atten_db(q_atten_db), .i_atten_db(i_atten_db),
  .conv_busy(conv_busy), .completion_event(completion_event));

// ===== sim/tb.sv
`timescale 1ns/100ps
module tb;
  localparam logic [7:0] VER = 8'h3C; // arbitrary value
  localparam int CONV = 8; // short count keeps the run brief
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic cmd_valid = 1'b0;
  logic [7:0] cmd_code = 8'h00;
  logic [2:0] qg = 3'h0;
  logic [2:0] ig = 3'h0;
  logic [3:0] rng = 4'h0;
  logic [2:0] pin = 3'h0;
  logic [3:0] hp = 4'h0;
  logic [3:0] lp = 4'h0;
  logic [7:0] sample = 8'h00;
  logic ext = 1'b0;
  logic [2:0] sup = 3'h0;
  logic [2:0] fin = 3'h0;
  logic ac = 1'b1;
  logic [4:0] q_atten_db;
  logic [4:0] i_atten_db;
  logic conv_busy;
  logic [3:0] completion_event;
  logic [7:0] st = 8'h04;
  logic [31:0] rd;
  logic err;
  int fail_count = 0;
  int checked = 0;

  always #4 pclk = ~pclk;

  paged_status_readout #(.VERSION(VER), .CONV_CYCLES(CONV)) paged_status_readout_inst (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .q_gain_request(qg), .i_gain_request(ig),
    .oscillator_range_readout(rng), .vco_pin_level(pin), .highpass_trim_code(hp),
    .lowpass_trim_code(lp), .converter_sample(sample), .ext_osc_detected(ext),
    .supply_level_in_use(sup), .anticollision_active(ac), .vco_range_finished(fin[2]),
    .supply_finished(fin[1]), .filter_cal_finished(fin[0]), .q_atten_db(q_atten_db),
    .i_atten_db(i_atten_db), .conv_busy(conv_busy), .completion_event(completion_event));

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic end_of_test;
    if (fail_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 16) begin
      fail_count++;
      end_of_test();
    end
  endtask

  task automatic rdchk(input string what, input logic [11:0] a, input logic [7:0] exp);
    apb(1'b0, a, 32'h00000000);
    cmp(what, {24'h000000, exp}, rd);
  endtask

  // one-cycle pulse; edge after the raise is the taking edge
  task automatic cmd(input logic [7:0] c);
    @(posedge pclk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    @(posedge pclk);
    cmd_valid <= 1'b0;
  endtask

  task automatic pulse(input int k);
    @(posedge pclk);
    fin[k] <= 1'b1;
    @(posedge pclk);
    fin[k] <= 1'b0;
    @(negedge pclk);
    cmp("event", 32'h00000001 << (k + 1), {28'h0000000, completion_event});
  endtask

  task automatic wait_idle(output int n);
    for (n = 0; n < 100; n++) begin
      @(negedge pclk);
      if (conv_busy === 1'b0) break;
    end
    if (n == 100) begin
      fail_count++;
      end_of_test();
    end
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_bank;
    rdchk("version", 12'h0CC, VER);
    rdchk("page reset", 12'h0C0, 8'h00);
    apb(1'b1, 12'h0CC, 32'h000000FF);
    apb(1'b1, 12'h0B8, 32'h000000FF);
    rdchk("version after write", 12'h0CC, VER);
    rdchk("status after write", 12'h0B8, st);
    @(posedge pclk);
    ce <= 1'b0;
    apb(1'b1, 12'h0C0, 32'h000000F0);
    ce <= 1'b1;
    rdchk("page frozen", 12'h0C0, 8'h00);
    apb(1'b0, 12'h100, 32'h00000000);
    cmp("unmapped error", 32'h00000001, {31'h00000000, err});
  endtask

  task automatic t_views;
    @(posedge pclk);
    rng <= 4'hA;
    pin <= 3'h5;
    hp <= 4'hC;
    lp <= 4'h3;
    ext <= 1'b1;
    apb(1'b1, 12'h0C0, 32'h00000010);
    rdchk("vco view", 12'h0B0, 8'hAD);
    apb(1'b1, 12'h0C0, 32'h00000020);
    rdchk("trim view", 12'h0B0, 8'hC3);
    apb(1'b1, 12'h0C0, 32'h0000005F);
    rdchk("page readback", 12'h0C0, 8'h50);
    rdchk("osc view", 12'h0B4, 8'h80);
    rdchk("vco view again", 12'h0B0, 8'hAD);
    @(posedge pclk);
    ext <= 1'b0;
    sup <= 3'h7;
    rdchk("supply top", 12'h0B4, 8'h07);
    apb(1'b1, 12'h0C0, 32'h000000F0);
    rdchk("unused c view", 12'h0B0, 8'h00);
    rdchk("unused d view", 12'h0B4, 8'h00);
    apb(1'b1, 12'h0C0, 32'h00000000);
  endtask

  task automatic t_gain;
    cmd(status_bank_pkg::CMD_GAIN_ON);
    st[1] = 1'b1;
    @(posedge pclk);
    qg <= 3'h3;
    ig <= 3'h2;
    repeat (3) @(posedge pclk);
    rdchk("gain view", 12'h0B0, 8'h1A);
    cmp("q atten", 32'h00000009, {27'h0000000, q_atten_db});
    cmp("i atten", 32'h00000006, {27'h0000000, i_atten_db});
    @(posedge pclk);
    qg <= 3'h6; // out-of-range code must leave the level alone
    ig <= 3'h4;
    repeat (3) @(posedge pclk);
    rdchk("gain view held", 12'h0B0, 8'h1C);
    cmp("q atten held", 32'h00000009, {27'h0000000, q_atten_db});
    cmp("i atten top", 32'h0000000C, {27'h0000000, i_atten_db});
    rdchk("status gain on", 12'h0B8, st);
    cmd(status_bank_pkg::CMD_GAIN_OFF);
    st[1] = 1'b0;
    repeat (2) @(posedge pclk);
    cmp("q atten off", 32'h00000000, {27'h0000000, q_atten_db});
    cmp("i atten off", 32'h00000000, {27'h0000000, i_atten_db});
    rdchk("status gain off", 12'h0B8, st);
  endtask

  task automatic t_conv;
    int n;
    @(posedge pclk);
    sample <= 8'h5B;
    cmd(status_bank_pkg::CMD_TRIG_CONV);
    @(negedge pclk);
    cmp("busy", 32'h00000001, {31'h00000000, conv_busy});
    wait_idle(n);
    cmp("conversion length", CONV, n + 1);
    st[3] = 1'b1;
    rdchk("result", 12'h0B4, 8'h5B);
    rdchk("status conv", 12'h0B8, st);
    @(posedge pclk);
    sample <= 8'hC4;
    cmd(status_bank_pkg::CMD_TRIG_CONV);
    st[3] = 1'b0;
    rdchk("status reissue", 12'h0B8, st);
    wait_idle(n);
    st[3] = 1'b1;
    rdchk("second result", 12'h0B4, 8'hC4);
  endtask

  task automatic t_flags;
    cmd(status_bank_pkg::CMD_VCO_AUTO);
    cmd(status_bank_pkg::CMD_SUPPLY_AUTO);
    cmd(status_bank_pkg::CMD_FILTER_CAL);
    pulse(2);
    pulse(1);
    pulse(0);
    st[6:4] = 3'h7;
    repeat (3) @(posedge pclk);
    rdchk("flags set", 12'h0B8, st);
    cmd(status_bank_pkg::CMD_VCO_MAN);
    cmd(status_bank_pkg::CMD_SUPPLY_MAN);
    st[6:5] = 2'h0;
    rdchk("flags cleared", 12'h0B8, st);
    cmd(status_bank_pkg::CMD_FILTER_CAL);
    cmd(status_bank_pkg::CMD_HOP_AUX);
    st[4] = 1'b0;
    st[0] = 1'b1;
    rdchk("hop aux", 12'h0B8, st);
    cmd(status_bank_pkg::CMD_HOP_MAIN);
    st[0] = 1'b0;
    rdchk("hop main", 12'h0B8, st);
    @(posedge pclk);
    cmd_valid <= 1'b1;
    cmd_code <= status_bank_pkg::CMD_FILTER_CAL;
    fin[0] <= 1'b1;
    @(posedge pclk);
    cmd_valid <= 1'b0;
    fin[0] <= 1'b0;
    st[4] = 1'b1;
    rdchk("set wins", 12'h0B8, st);
    @(posedge pclk);
    ac <= 1'b0;
    st[2] = 1'b0;
    rdchk("anticollision off", 12'h0B8, st);
  endtask

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_bank();
    t_views();
    t_gain();
    t_conv();
    t_flags();
    end_of_test();
  end
endmodule

// ===== src/conv_sequencer.sv
`timescale 1ns/100ps
module conv_sequencer #(
  parameter int CYCLES = status_bank_pkg::CONV_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic start,
  input wire logic [7:0] sample,
  output logic [7:0] result,
  output logic busy,
  output logic done
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  status_bank_pkg::conv_state_t state_reg;
  logic [CW-1:0] count_reg;

  assign busy = (state_reg == status_bank_pkg::CONV_BUSY);

  // ************************************************************
  // sequencer
  // ************************************************************
  // restart while busy begins a fresh full wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= status_bank_pkg::CONV_IDLE;
      count_reg <= '0;
    end else if (ce) begin
      case (state_reg)
        status_bank_pkg::CONV_IDLE: begin
          if (start) begin
            state_reg <= status_bank_pkg::CONV_BUSY;
            count_reg <= '0;
          end
        end
        status_bank_pkg::CONV_BUSY: begin
          if (start) begin
            count_reg <= '0;
          end else if (count_reg == LAST) begin
            state_reg <= status_bank_pkg::CONV_IDLE;
          end else begin
            count_reg <= count_reg + 1'b1;
          end
        end
        default: begin
          state_reg <= status_bank_pkg::CONV_IDLE;
        end
      endcase
    end
  end

  // result settles exactly the conversion time after the command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result <= 8'h00;
      done <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (busy && !start && count_reg == LAST) begin
        result <= sample;
        done <= 1'b1;
      end
    end
  end
endmodule

// ===== src/paged_status_readout.sv
// Added by the designer: the APB interface to the registers.
`timescale 1ns/100ps
// How it works
// - gain view at 2Ch: Q level bits 5:3, I level bits 2:0, bits 7:6 zero.
// - gain codes 0..4 are valid, 3 dB each, 0 to 12 dB.
// - gain codes 5..7 add no attenuation beyond what is applied.
// - VCO view at 2Ch: bits 7:4 show the 16-value range search result.
// - VCO view bits 2:0 show the measured VCO pin voltage step.
// - calibration view: high nibble high-pass code, low nibble low-pass code.
// - view 00 at 2Dh shows the 8-bit converter result.
// - conversion starts on its command; result valid 20 us later.
// - view 01 at 2Dh bit 7 shows external oscillator detected.
// - view 01 bits 2:0 show the supply level code in use.
// - bits 6:3 of oscillator and supply view read zero.
// - status bit 6 sets when a VCO range command completes, raising an event.
// - status bit 5 sets when a supply level command completes, raising an event.
// - status bit 4 sets when filter calibration completes, raising an event.
// - status bit 3 sets when a conversion completes, raising an event.
// - status bit 2 shows anti-collision support is enabled.
// - status bit 1 reflects completion of gain reduction on and off.
// - status bit 0 shows auxiliary synthesizer setting after hop commands.
// - address 33h returns a fixed version number.
// - page bits 7:6 choose the 2Dh view, bits 5:4 the 2Ch view.
module paged_status_readout #(
  parameter logic [7:0] VERSION = status_bank_pkg::VERSION_DEFAULT,
  parameter int CONV_CYCLES = status_bank_pkg::CONV_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [status_bank_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [2:0] q_gain_request,
  input wire logic [2:0] i_gain_request,
  input wire logic [3:0] oscillator_range_readout,
  input wire logic [2:0] vco_pin_level,
  input wire logic [3:0] highpass_trim_code,
  input wire logic [3:0] lowpass_trim_code,
  input wire logic [7:0] converter_sample,
  input wire logic ext_osc_detected,
  input wire logic [2:0] supply_level_in_use,
  input wire logic anticollision_active,
  input wire logic vco_range_finished,
  input wire logic supply_finished,
  input wire logic filter_cal_finished,
  output logic [4:0] q_atten_db,
  output logic [4:0] i_atten_db,
  output logic conv_busy,
  output logic [3:0] completion_event
);

  // ************************************************************
  // bus decode
  // ************************************************************
  logic [7:0] index;
  logic setup;
  logic wr_access;
  logic hit_mapped;
  logic [7:0] page_reg;
  logic [1:0] view_select_c;
  logic [1:0] view_select_d;

  assign index = paddr[status_bank_pkg::ADDR_LSB +: 8];
  assign setup = psel && !penable;
  assign wr_access = psel && penable && pwrite && ce;
  assign view_select_d = page_reg[status_bank_pkg::VIEW_D_HI:status_bank_pkg::VIEW_D_LO];
  assign view_select_c = page_reg[status_bank_pkg::VIEW_C_HI:status_bank_pkg::VIEW_C_LO];

  always_comb begin
    hit_mapped = 1'b0;
    if (paddr[status_bank_pkg::ADDR_W-1:status_bank_pkg::ADDR_LSB + 8] == '0 &&
        paddr[status_bank_pkg::ADDR_LSB-1:0] == '0) begin
      case (index)
        status_bank_pkg::IDX_GAIN_VIEW,
        status_bank_pkg::IDX_CONV_VIEW,
        status_bank_pkg::IDX_CMD_STATUS,
        status_bank_pkg::IDX_PAGE_SETTING,
        status_bank_pkg::IDX_CHIP_VERSION: hit_mapped = 1'b1;
        default: hit_mapped = 1'b0;
      endcase
    end
  end

  // answer comes in the first access cycle; data captured at setup
  assign pready = psel && penable;

  // ************************************************************
  // page setting (the only writable register)
  // ************************************************************
  // bank views ignore writes; only this index accepts data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page_reg <= status_bank_pkg::PAGE_RESET;
    end else if (wr_access && hit_mapped && index == status_bank_pkg::IDX_PAGE_SETTING) begin
      page_reg <= pwdata[7:0] & status_bank_pkg::PAGE_WRITE_MASK;
    end
  end

  // ************************************************************
  // command decode
  // ************************************************************
  logic cmd_take;
  logic issue_vco;
  logic issue_supply;
  logic issue_filter;
  logic issue_conv;

  assign cmd_take = cmd_valid && ce;
  assign issue_vco = cmd_take && (cmd_code == status_bank_pkg::CMD_VCO_AUTO ||
                                  cmd_code == status_bank_pkg::CMD_VCO_MAN);
  assign issue_supply = cmd_take && (cmd_code == status_bank_pkg::CMD_SUPPLY_AUTO ||
                                     cmd_code == status_bank_pkg::CMD_SUPPLY_MAN);
  assign issue_filter = cmd_take && cmd_code == status_bank_pkg::CMD_FILTER_CAL;
  assign issue_conv = cmd_take && cmd_code == status_bank_pkg::CMD_TRIG_CONV;

  // ************************************************************
  // converter
  // ************************************************************
  logic [7:0] conv_result;
  logic conv_done;

  conv_sequencer #(
    .CYCLES(CONV_CYCLES)
  ) u_conv (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .start(issue_conv),
    .sample(converter_sample),
    .result(conv_result),
    .busy(conv_busy),
    .done(conv_done)
  );

  // ************************************************************
  // completion flags
  // ************************************************************
  logic [3:0] done_set;
  logic [3:0] done_clear;
  logic [3:0] done_reg;

  assign done_set = {vco_range_finished, supply_finished, filter_cal_finished, conv_done};
  assign done_clear = {issue_vco, issue_supply, issue_filter, issue_conv};

  // set wins over a clear in the same cycle
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_flag
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          done_reg[g] <= 1'b0;
        end else if (ce) begin
          if (done_set[g]) begin
            done_reg[g] <= 1'b1;
          end else if (done_clear[g]) begin
            done_reg[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // one-cycle event per completion, for the interrupt logic outside
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      completion_event <= 4'h0;
    end else if (ce) begin
      completion_event <= done_set;
    end
  end

  // ************************************************************
  // gain reduction and hop state
  // ************************************************************
  logic gain_on_reg;
  logic aux_sel_reg;
  logic [2:0] q_gain_reg;
  logic [2:0] i_gain_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gain_on_reg <= 1'b0;
    end else if (cmd_take) begin
      if (cmd_code == status_bank_pkg::CMD_GAIN_ON) begin
        gain_on_reg <= 1'b1;
      end else if (cmd_code == status_bank_pkg::CMD_GAIN_OFF) begin
        gain_on_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_sel_reg <= 1'b0;
    end else if (cmd_take) begin
      if (cmd_code == status_bank_pkg::CMD_HOP_AUX) begin
        aux_sel_reg <= 1'b1;
      end else if (cmd_code == status_bank_pkg::CMD_HOP_MAIN) begin
        aux_sel_reg <= 1'b0;
      end
    end
  end

  // out-of-range requests leave the applied level where it was
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_gain_reg <= 3'h0;
      i_gain_reg <= 3'h0;
    end else if (ce) begin
      if (q_gain_request <= status_bank_pkg::GAIN_CODE_MAX) begin
        q_gain_reg <= q_gain_request;
      end
      if (i_gain_request <= status_bank_pkg::GAIN_CODE_MAX) begin
        i_gain_reg <= i_gain_request;
      end
    end
  end

  // attenuation only applies while gain reduction is on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_atten_db <= 5'h00;
      i_atten_db <= 5'h00;
    end else if (ce) begin
      q_atten_db <= gain_on_reg ? 5'(q_gain_reg * status_bank_pkg::GAIN_STEP_DB) : 5'h00;
      i_atten_db <= gain_on_reg ? 5'(i_gain_reg * status_bank_pkg::GAIN_STEP_DB) : 5'h00;
    end
  end

  // ************************************************************
  // read mux
  // ************************************************************
  logic [7:0] view_c;
  logic [7:0] view_d;
  logic [7:0] cmd_status;
  logic [7:0] read_value;

  // shows the applied levels, so codes 5..7 never appear
  always_comb begin
    case (view_select_c)
      status_bank_pkg::VIEW_0: view_c = {2'b00, q_gain_reg, i_gain_reg};
      status_bank_pkg::VIEW_1: view_c = {oscillator_range_readout, 1'b1, vco_pin_level};
      status_bank_pkg::VIEW_2: view_c = {highpass_trim_code, lowpass_trim_code};
      default: view_c = 8'h00;
    endcase
  end

  always_comb begin
    case (view_select_d)
      status_bank_pkg::VIEW_0: view_d = conv_result;
      status_bank_pkg::VIEW_1: view_d = {ext_osc_detected, 4'h0, supply_level_in_use};
      default: view_d = 8'h00;
    endcase
  end

  always_comb begin
    cmd_status = 8'h00;
    cmd_status[status_bank_pkg::BIT_VCO_DONE] = done_reg[3];
    cmd_status[status_bank_pkg::BIT_SUPPLY_DONE] = done_reg[2];
    cmd_status[status_bank_pkg::BIT_FILTER_DONE] = done_reg[1];
    cmd_status[status_bank_pkg::BIT_CONV_DONE] = done_reg[0];
    cmd_status[status_bank_pkg::BIT_ANTICOLL] = anticollision_active;
    cmd_status[status_bank_pkg::BIT_GAIN_ON] = gain_on_reg;
    cmd_status[status_bank_pkg::BIT_AUX_SEL] = aux_sel_reg;
  end

  always_comb begin
    read_value = 8'h00;
    if (hit_mapped) begin
      case (index)
        status_bank_pkg::IDX_GAIN_VIEW: read_value = view_c;
        status_bank_pkg::IDX_CONV_VIEW: read_value = view_d;
        status_bank_pkg::IDX_CMD_STATUS: read_value = cmd_status;
        status_bank_pkg::IDX_PAGE_SETTING: read_value = page_reg;
        status_bank_pkg::IDX_CHIP_VERSION: read_value = VERSION;
        default: read_value = 8'h00;
      endcase
    end
  end

  // ************************************************************
  // bus answer registers
  // ************************************************************
  // captured in setup so data is steady through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce && setup) begin
      prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, read_value};
      pslverr <= !hit_mapped;
    end
  end

endmodule

// ===== src/status_bank_pkg.sv
package status_bank_pkg;

  // ************************************************************
  // register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [7:0] IDX_GAIN_VIEW = 8'h2C;
  localparam logic [7:0] IDX_CONV_VIEW = 8'h2D;
  localparam logic [7:0] IDX_CMD_STATUS = 8'h2E;
  localparam logic [7:0] IDX_PAGE_SETTING = 8'h30;
  localparam logic [7:0] IDX_CHIP_VERSION = 8'h33;
  localparam int ADDR_LSB = 2;
  localparam int ADDR_W = 12;

  // ************************************************************
  // page setting fields
  // ************************************************************
  localparam int VIEW_D_HI = 7;
  localparam int VIEW_D_LO = 6;
  localparam int VIEW_C_HI = 5;
  localparam int VIEW_C_LO = 4;
  localparam logic [7:0] PAGE_RESET = 8'h00;
  localparam logic [7:0] PAGE_WRITE_MASK = 8'hF0;

  // ************************************************************
  // view codes
  // ************************************************************
  localparam logic [1:0] VIEW_0 = 2'h0;
  localparam logic [1:0] VIEW_1 = 2'h1;
  localparam logic [1:0] VIEW_2 = 2'h2;

  // ************************************************************
  // command status bits
  // ************************************************************
  localparam int BIT_VCO_DONE = 6;
  localparam int BIT_SUPPLY_DONE = 5;
  localparam int BIT_FILTER_DONE = 4;
  localparam int BIT_CONV_DONE = 3;
  localparam int BIT_ANTICOLL = 2;
  localparam int BIT_GAIN_ON = 1;
  localparam int BIT_AUX_SEL = 0;

  // ************************************************************
  // direct command codes
  // ************************************************************
  localparam logic [7:0] CMD_HOP_MAIN = 8'h84;
  localparam logic [7:0] CMD_HOP_AUX = 8'h85;
  localparam logic [7:0] CMD_TRIG_CONV = 8'h87;
  localparam logic [7:0] CMD_FILTER_CAL = 8'h88;
  localparam logic [7:0] CMD_SUPPLY_AUTO = 8'hA2;
  localparam logic [7:0] CMD_SUPPLY_MAN = 8'hA3;
  localparam logic [7:0] CMD_VCO_AUTO = 8'hA4;
  localparam logic [7:0] CMD_VCO_MAN = 8'hA5;
  localparam logic [7:0] CMD_GAIN_ON = 8'hA6;
  localparam logic [7:0] CMD_GAIN_OFF = 8'hA7;

  // ************************************************************
  // gain reduction
  // ************************************************************
  localparam logic [2:0] GAIN_CODE_MAX = 3'h4;
  localparam logic [4:0] GAIN_STEP_DB = 5'h03;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int CONV_TIME_NS = 20000;
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // arbitrary version value
  localparam logic [7:0] VERSION_DEFAULT = 8'hA5;

  typedef enum logic [1:0] {
    CONV_IDLE = 2'b01,
    CONV_BUSY = 2'b10
  } conv_state_t;

endpackage
